// >>> hw/bfhs_map.svh
// constants for the buck fault and hiccup sequencer
`ifndef BFHS_MAP_SVH
`define BFHS_MAP_SVH
// clock rate in kHz (10 MHz switching clock)
`define BFHS_CLK_KHZ 10000
// cycles past soft-start before a low feedback trips hiccup
`define BFHS_FB_HICCUP_DLY 16'd1024
// hiccup timeout in half-rate cycles
`define BFHS_HICCUP_HALF_CYC 16'd32768
// output-status release delay in switching cycles
`define BFHS_STATUS_DLY 16'd1024
// default soft-start length in half-rate cycles
`define BFHS_SS_DEFAULT 16'd5000
`endif

// >>> hw/bfhs_pkg.sv
// types for the buck fault and hiccup sequencer
package bfhs_pkg;
	typedef enum logic [2:0] {
		BFHS_OFF = 3'b000,
		BFHS_WAIT_PWM = 3'b001,
		BFHS_SOFT = 3'b010,
		BFHS_RUN = 3'b011,
		BFHS_HICCUP = 3'b100,
		BFHS_THERMAL = 3'b101
	} bfhs_state_t;
endpackage : bfhs_pkg

// >>> hw/bfhs_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
module bfhs_sync #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta; // first stage, read only by the second

	// plain two-stage capture; reset to zero so all comparators look inactive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : bfhs_sync

// >>> hw/bfhs_seq.sv
// fault, hiccup and start-up sequencer of the step-down converter
// Behaviour
// - peak current cuts high side for cycle
// - one runaway event enters hiccup
// - low feedback trips hiccup 1024 after soft-start
// - hiccup holds switches off 32768 half cycles
// - hiccup expiry restarts soft-start
// - failed retry runs soft-start plus 1024
// - half rate until output reaches 66.7%
// - status released 1024 cycles after good rise
// - status low below good-fall threshold
// - status low in thermal or enable low
// - prebiased start keeps both switches off
// - switching starts at first pwm on request
// - over-temperature stops switching, thermal state
// - cooled sensor restarts through soft-start
// - supply undervoltage forces converter off
`timescale 1ns/1ns
`include "bfhs_map.svh"
module bfhs_seq #(
	parameter logic [15:0] SS_HALF_CYC = `BFHS_SS_DEFAULT, // soft-start length, half-rate cycles
	parameter logic [15:0] HICCUP_HALF_CYC = `BFHS_HICCUP_HALF_CYC // hiccup timeout, half-rate cycles
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic enable_ok, // enable_undervoltage_input above threshold
	input wire logic supply_ok, // internal_supply_rail above its undervoltage threshold
	input wire logic peak_over, // current above peak_current_threshold
	input wire logic runaway_over, // current above runaway_current_threshold
	input wire logic fb_low, // feedback at or below feedback_hiccup_threshold
	input wire logic out_two_thirds, // output at 66.7% of nominal
	input wire logic out_good_rise, // output above output_good_rise_threshold
	input wire logic out_good_fall_low, // output below output_good_fall_threshold
	input wire logic over_temp, // sensor: hot (with 10 degree hysteresis inside)
	input wire logic pwm_on_req, // pwm comparator on-pulse request
	input wire logic cycle_start, // start of each switching cycle
	output logic hs_gate_en, // high-side switch enable
	output logic ls_gate_en, // low-side switch enable
	output logic half_rate, // converter switching at half frequency
	output logic status_oe_n, // open-drain status: low while pulling line low
	output logic status_o, // driven level of status line, always zero
	output bfhs_pkg::bfhs_state_t seq_state // sequencer state
);
	import bfhs_pkg::*;

	localparam int NS = 11;
	logic [NS-1:0] raw_in; // gathered asynchronous inputs
	logic [NS-1:0] syn; // synchronised copy
	assign raw_in = {cycle_start, pwm_on_req, over_temp, out_good_fall_low, out_good_rise,
		out_two_thirds, fb_low, runaway_over, peak_over, supply_ok, enable_ok};

	// every analog decision crosses here before use
	bfhs_sync #(.WIDTH(NS)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(raw_in),
		.sync_out(syn)
	);

	wire s_en = syn[0]; // enable level
	wire s_sup = syn[1]; // supply level
	wire s_peak = syn[2]; // peak limit
	wire s_run = syn[3]; // runaway limit
	wire s_fblow = syn[4]; // feedback low
	wire s_23 = syn[5]; // two-thirds reached
	wire s_rise = syn[6]; // good rise
	wire s_fall = syn[7]; // good fall
	wire s_hot = syn[8]; // over temperature
	wire s_pwm = syn[9]; // first on request
	wire s_cyc = syn[10]; // cycle start

	bfhs_state_t state; // sequencer state
	bfhs_state_t next_state; // next sequencer state
	logic half_tick; // toggles every clock
	logic [15:0] cnt; // shared state timer
	logic [15:0] next_cnt; // next timer value
	logic ss_done; // soft-start ramp finished
	logic next_ss_done; // next ramp-finished flag
	logic full_rate; // 66.7% reached during this start
	logic peak_block; // high side blocked until next cycle
	logic [15:0] stat_cnt; // status release delay counter
	logic status_good; // status released
	logic cyc_d; // delayed cycle start for edge detect

	// saturating increment, shared by both timers
	function automatic logic [15:0] inc16(input logic [15:0] v);
		inc16 = (v == 16'hffff) ? v : v + 16'h0001;
	endfunction : inc16

	wire power_ok = s_en & s_sup;
	wire cyc_edge = s_cyc & ~cyc_d; // new switching cycle
	wire tick_act = full_rate | half_tick; // active timing tick, half rate before full
	wire ss_limit = (cnt >= SS_HALF_CYC - 16'h0001) & half_tick;
	wire fb_timeout = (cnt >= `BFHS_FB_HICCUP_DLY - 16'h0001);
	wire hic_done = half_tick & (cnt >= HICCUP_HALF_CYC - 16'h0001);

	// half-rate enable: a toggle, not a derived clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_tick <= 1'b0;
		end else begin
			half_tick <= ~half_tick;
		end
	end

	// state transition decisions; fault priority: power, thermal, runaway
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_ss_done = ss_done;
		if (!power_ok) begin
			next_state = BFHS_OFF;
			next_cnt = 16'h0000;
			next_ss_done = 1'b0;
		end else if (s_hot) begin
			next_state = BFHS_THERMAL;
			next_cnt = 16'h0000;
			next_ss_done = 1'b0;
		end else if (s_run && (state == BFHS_SOFT || state == BFHS_RUN)) begin
			next_state = BFHS_HICCUP;
			next_cnt = 16'h0000;
			next_ss_done = 1'b0;
		end else begin
			case (state)
				BFHS_OFF, BFHS_THERMAL: begin
					next_state = BFHS_WAIT_PWM;
					next_cnt = 16'h0000;
				end
				BFHS_WAIT_PWM: begin
					if (s_pwm) begin
						next_state = BFHS_SOFT;
					end
				end
				BFHS_SOFT: begin
					if (!ss_done) begin
						if (ss_limit) begin
							next_ss_done = 1'b1;
							next_cnt = 16'h0000;
						end else if (half_tick) begin
							next_cnt = inc16(cnt);
						end
					end else if (!s_fblow) begin
						next_state = BFHS_RUN;
						next_cnt = 16'h0000;
					end else if (fb_timeout) begin
						next_state = BFHS_HICCUP;
						next_cnt = 16'h0000;
						next_ss_done = 1'b0;
					end else begin
						next_cnt = inc16(cnt);
					end
				end
				BFHS_RUN: begin
					if (!s_fblow) begin
						next_cnt = 16'h0000;
					end else if (fb_timeout) begin
						next_state = BFHS_HICCUP;
						next_cnt = 16'h0000;
						next_ss_done = 1'b0;
					end else begin
						next_cnt = inc16(cnt);
					end
				end
				BFHS_HICCUP: begin
					if (hic_done) begin
						next_state = BFHS_WAIT_PWM;
						next_cnt = 16'h0000;
					end else if (half_tick) begin
						next_cnt = inc16(cnt);
					end
				end
				default: begin
					next_state = BFHS_OFF;
					next_cnt = 16'h0000;
					next_ss_done = 1'b0;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= BFHS_OFF;
			cnt <= 16'h0000;
			ss_done <= 1'b0;
			cyc_d <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ss_done <= next_ss_done;
			cyc_d <= s_cyc;
		end
	end

	// frequency selection; every fresh start goes back to half rate
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			full_rate <= 1'b0;
		end else if (next_state == BFHS_OFF || next_state == BFHS_WAIT_PWM
			|| next_state == BFHS_HICCUP || next_state == BFHS_THERMAL) begin
			full_rate <= 1'b0;
		end else if (s_23) begin
			full_rate <= 1'b1;
		end
	end

	// peak limit latch: cleared only at the next cycle start, so the
	// high side stays off for the remainder of the cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_block <= 1'b0;
		end else if (s_peak) begin
			peak_block <= 1'b1;
		end else if (cyc_edge) begin
			peak_block <= 1'b0;
		end
	end

	wire switching = (state == BFHS_SOFT) || (state == BFHS_RUN);
	// both switches off until the first on request; avoids sinking from a prebias
	assign hs_gate_en = switching & ~peak_block & ~s_peak;
	assign ls_gate_en = switching;
	assign half_rate = ~full_rate;
	assign seq_state = state;

	// status delay: counts switching cycles (tick_act) while output is good
	wire status_kill = s_fall | s_hot | ~s_en | ~s_sup | ~switching;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_cnt <= 16'h0000;
			status_good <= 1'b0;
		end else if (status_kill) begin
			stat_cnt <= 16'h0000;
			status_good <= 1'b0;
		end else if (status_good) begin
			stat_cnt <= stat_cnt;
		end else if (s_rise && tick_act) begin
			if (stat_cnt >= `BFHS_STATUS_DLY - 16'h0001) begin
				status_good <= 1'b1;
			end
			stat_cnt <= inc16(stat_cnt);
		end else if (!s_rise) begin
			stat_cnt <= 16'h0000;
		end
	end

	assign status_oe_n = status_good; // low enable = pulling the line low
	assign status_o = 1'b0;

	// note: timing granularity is the core clock; tick_act models one
	// switching cycle per clock at full rate and per two at half rate
endmodule : bfhs_seq

// >>> verif/bfhs_chk.sv
// port-level assertions for the fault and hiccup sequencer
`timescale 1ns/1ns
module bfhs_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic enable_ok,
	input wire logic supply_ok,
	input wire logic peak_over,
	input wire logic runaway_over,
	input wire logic out_two_thirds,
	input wire logic out_good_fall_low,
	input wire logic over_temp,
	input wire logic hs_gate_en,
	input wire logic ls_gate_en,
	input wire logic half_rate,
	input wire logic status_oe_n,
	input wire bfhs_pkg::bfhs_state_t seq_state
);
	import bfhs_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// four samples cover the two sync flops plus the reacting edge
	AST_PEAK_CUT: assert property (peak_over [*4] |-> !hs_gate_en)
		else $error("high side enabled during peak limit");
	// inputs taken at one edge steer the state two edges later; the state then moves on the next
	AST_RUNAWAY: assert property ((runaway_over && supply_ok && enable_ok && !over_temp) ##2
		seq_state inside {BFHS_SOFT, BFHS_RUN} |=> seq_state == BFHS_HICCUP)
		else $error("runaway did not enter hiccup");
	AST_HICCUP_OFF: assert property (seq_state == BFHS_HICCUP |-> !hs_gate_en && !ls_gate_en)
		else $error("switching during hiccup");
	AST_WAIT_OFF: assert property (seq_state inside {BFHS_OFF, BFHS_WAIT_PWM} |-> !hs_gate_en && !ls_gate_en)
		else $error("switching before first pwm request");
	AST_HALF: assert property ((!out_two_thirds) [*4] ##0 seq_state == BFHS_SOFT |-> half_rate)
		else $error("full rate below two thirds");
	AST_FALL_STATUS: assert property (out_good_fall_low [*4] |-> !status_oe_n)
		else $error("status released with low output");
	AST_EN_STATUS: assert property ((!enable_ok) [*4] |-> !status_oe_n)
		else $error("status released with enable low");
	AST_THERMAL: assert property ((over_temp && supply_ok && enable_ok) [*4] |->
		seq_state == BFHS_THERMAL && !hs_gate_en && !ls_gate_en && !status_oe_n)
		else $error("thermal shutdown not taken");
	AST_PWR_LOSS: assert property ((!supply_ok) [*4] |-> seq_state == BFHS_OFF && !hs_gate_en)
		else $error("converter on with supply low");
endmodule : bfhs_chk
bind bfhs_seq bfhs_chk bfhs_chk_i (.*);

// >>> verif/bfhs_stage.sv
// behavioural power stage: output level, comparators and pwm requests
`timescale 1ns/1ns
module bfhs_stage (
	input wire logic core_clk,
	input wire logic hs_gate_en,
	input wire logic half_rate,
	input wire logic short_out, // bench: output shorted to ground
	output logic pwm_on_req,
	output logic cycle_start,
	output logic fb_low,
	output logic out_two_thirds,
	output logic out_good_rise,
	output logic out_good_fall_low
);
	logic [6:0] vout = 7'h00; // output in percent of nominal
	logic ph = 1'b0; // switching phase, also gives cycle starts
	// charges while the high side may switch (every other clock at half rate), load drains it while the high side is off
	always_ff @(posedge core_clk) begin
		ph <= ~ph;
		if (short_out) begin
			vout <= 7'h00;
		end else if (hs_gate_en && (!half_rate || ph)) begin
			vout <= (vout < 7'h64) ? vout + 7'h01 : vout;
		end else if (!hs_gate_en && vout != 7'h00) begin
			vout <= vout - 7'h01;
		end
	end
	assign cycle_start = ph;
	// a prebiased output asks for no pulse until it sags below target
	assign pwm_on_req = vout < 7'h5f;
	assign fb_low = vout < 7'h40;
	assign out_two_thirds = vout >= 7'h43;
	assign out_good_rise = vout >= 7'h60;
	assign out_good_fall_low = vout < 7'h5c;
endmodule : bfhs_stage

// >>> verif/tb_top.sv
// self-checking bench for the fault and hiccup sequencer
`timescale 1ns/1ns
module tb_top;
	import bfhs_pkg::*;
	localparam int SS = 8; // short soft-start, half-rate cycles
	localparam int HC = 16; // short hiccup timeout, half-rate cycles
	localparam int DLY = 1024; // fault delay in clocks, status delay in switching cycles
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic enable_ok = 1'b1, supply_ok = 1'b1, peak_over = 1'b0, runaway_over = 1'b0, over_temp = 1'b0;
	logic short_out = 1'b0; // output short fault in the stage model
	logic pwm_on_req, cycle_start, fb_low, out_two_thirds, out_good_rise, out_good_fall_low;
	logic hs_gate_en, ls_gate_en, half_rate, status_oe_n, status_o;
	bfhs_state_t seq_state;
	int mismatches = 0;
	int tests_run = 0;
	int n;
	always #50 core_clk = ~core_clk;
	bfhs_seq #(.SS_HALF_CYC(16'(SS)), .HICCUP_HALF_CYC(16'(HC))) bfhs_seq_i (.*);
	bfhs_stage bfhs_stage_i (.*);
	// advance k cycles, landing just after the edge
	task automatic tk(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tk
	// range compare; an unknown never lands inside
	task automatic chk(input string what, input int lo, input int hi, input logic [31:0] got);
		tests_run++;
		if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
			mismatches++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk
	// expected clocks: a half-rate cycle takes two clocks, a full-rate one takes one
	function automatic int exp_cyc(input int half_cyc, input int full_cyc);
		return 2 * half_cyc + full_cyc;
	endfunction : exp_cyc
	// cycles until the sequencer shows a state, capped
	task automatic wait_st(input bfhs_state_t st, input int lim, output int cnt);
		for (cnt = 0; seq_state !== st && cnt < lim; cnt++) tk(1);
	endtask : wait_st
	task automatic end_sim;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	// watchdog well beyond the expected run of about 6k cycles
	initial begin
		#(100 * 60000);
		mismatches++;
		end_sim();
	end
	initial begin
		void'($urandom(29));
		tk(8);
		rst_n = 1'b1;
		wait_st(BFHS_RUN, 3000, n);
		chk("startup run", 0, 2999, n);
		for (n = 0; out_good_rise !== 1'b1 && n < 500; n++) tk(1);
		for (n = 0; status_oe_n !== 1'b1 && n < 1100; n++) tk(1);
		chk("status release delay", exp_cyc(0, DLY), exp_cyc(0, DLY) + 8, n);
		chk("status drive level", 0, 0, status_o);
		$display("test startup done");
		// random peak pulses must not move the state
		repeat (300) begin
			peak_over = 1'($urandom_range(0, 3) == 0);
			tk($urandom_range(1, 6));
		end
		peak_over = 1'b0;
		tk(8);
		chk("state after peaks", BFHS_RUN, BFHS_RUN, seq_state);
		// corner: one held peak, then the high side must wait for the next cycle start
		peak_over = 1'b1;
		tk(3);
		chk("high side off at peak", 0, 0, hs_gate_en);
		peak_over = 1'b0;
		for (n = 0; hs_gate_en !== 1'b1 && n < 10; n++) tk(1);
		chk("high side back at next cycle", 2, 6, n);
		runaway_over = 1'b1;
		tk(4);
		runaway_over = 1'b0;
		wait_st(BFHS_HICCUP, 10, n);
		chk("runaway to hiccup", 0, 9, n);
		wait_st(BFHS_WAIT_PWM, 200, n);
		chk("hiccup length", exp_cyc(HC, 0) - 2, exp_cyc(HC, 0) + 2, n);
		$display("test runaway done");
		wait_st(BFHS_RUN, 3000, n);
		short_out = 1'b1;
		wait_st(BFHS_HICCUP, 1200, n);
		chk("low feedback hiccup", exp_cyc(0, DLY), exp_cyc(0, DLY) + 8, n);
		wait_st(BFHS_SOFT, 200, n);
		chk("hiccup retry", exp_cyc(HC, 0) - 1, exp_cyc(HC, 0) + 2, n);
		wait_st(BFHS_HICCUP, 1200, n);
		chk("failed retry length", exp_cyc(SS, DLY) - 2, exp_cyc(SS, DLY) + 8, n);
		short_out = 1'b0;
		$display("test short done");
		wait_st(BFHS_RUN, 3000, n);
		over_temp = 1'b1;
		wait_st(BFHS_THERMAL, 8, n);
		chk("thermal entry", 0, 6, n);
		tk($urandom_range(5, 40));
		over_temp = 1'b0;
		wait_st(BFHS_SOFT, 200, n);
		chk("thermal restart", 3, 5, n);
		$display("test thermal done");
		wait_st(BFHS_RUN, 3000, n);
		// the line must be released first, or the enable check proves nothing
		for (n = 0; status_oe_n !== 1'b1 && n < 1200; n++) tk(1);
		chk("status before enable drop", 1, 1199, n);
		enable_ok = 1'b0;
		tk(4);
		chk("status with enable low", 0, 0, status_oe_n);
		enable_ok = 1'b1;
		// output left near full scale: no pwm request until it sags, so no switching
		wait_st(BFHS_WAIT_PWM, 8, n);
		wait_st(BFHS_SOFT, 40, n);
		chk("prebias wait for pwm", 3, 8, n);
		wait_st(BFHS_RUN, 3000, n);
		supply_ok = 1'b0;
		wait_st(BFHS_OFF, 8, n);
		chk("supply loss off", 2, 4, n);
		supply_ok = 1'b1;
		wait_st(BFHS_RUN, 3000, n);
		chk("supply return run", 0, 2999, n);
		$display("test power done");
		end_sim();
	end
endmodule : tb_top
